// [common/hics_map.vh]
// Constants for the haptic command slave: address, commands, revision.
// Assumes inclusion by bare name from design and testbench files.
`ifndef HICS_MAP_VH
`define HICS_MAP_VH
`define HICS_SLAVE_ADDR    7'h10
`define HICS_LAST_EFFECT   8'h0D
`define HICS_CMD_REVISION  8'h0E
`define HICS_CMD_ABORT     8'h0F
`define HICS_REV_BYTES     2
// Arbitrary revision value
`define HICS_REV_DEFAULT   16'h0100
`endif

// [design/hics_command_slave.v]
// Serial-bus command slave: receives two-byte haptic commands, checks
// them, and issues effect and abort actions at the Stop, revision at a Restart.
// Assumes an external pull-up on the data line and a slow bus clock
// relative to clk (several clk cycles per bus clock phase).
`timescale 1ns/10ps
`include "hics_map.vh"

// How it works
// - Data rising while clock high is a Stop, ending the transfer.
// - Stop returns the serial logic to idle, awaiting a new Start.
// - Any format violation abandons the frame; nothing is acted on.
// - Extra Start or Stop aborts the frame in progress.
// - First byte holds address 0010000 plus direction; only it matches.
// - Effects 0x00..0x0D; second byte is two's complement of first.
// - Effect playback starts only once the closing Stop completes.
// - Abort pair 0x0F 0xF1 stops playback at the closing Stop.
// - Revision pair 0x0E 0xF2 then Restart stages revision bytes for a read.
// - Revision read starts at the top byte and advances per byte.
// - Bytes keep coming while the master acknowledges each one.
// - Restart or Stop in a data bit position cancels the command.
// - Commands failing the complement check are discarded.
// - Write actions fire only after full valid command and Stop.
// - Undefined command releases data and ignores bus until Start.
// - Acknowledge matching address, a read only with revision staged; never general call or others.
// - Data falling while clock high is a Start.
module hics_command_slave #(
  parameter [15:0] REV_VALUE = `HICS_REV_DEFAULT
) (
  // Clock and reset
  input  wire       clk,
  input  wire       resetn,
  // Serial bus pins
  input  wire       sclIn,
  input  wire       sdaIn,
  output reg        sdaOut,
  output reg        sdaOe,
  // Haptic actions
  output reg        effectStart,
  output reg  [3:0] effectIndex,
  output reg        effectAbort,
  output reg        busy
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_AACK = 7'h04;
  localparam [6:0] S_WBYT = 7'h08;
  localparam [6:0] S_WACK = 7'h10;
  localparam [6:0] S_RBYT = 7'h20;
  localparam [6:0] S_RACK = 7'h40;

  wire sclLvl;
  wire sclRise;
  wire sclFall;
  wire sdaLvl;
  wire sdaRise;
  wire sdaFall;

  hics_pin_sync uSclSync (
    .clk    (clk),
    .resetn (resetn),
    .pinIn  (sclIn),
    .level  (sclLvl),
    .rise   (sclRise),
    .fall   (sclFall)
  );

  hics_pin_sync uSdaSync (
    .clk    (clk),
    .resetn (resetn),
    .pinIn  (sdaIn),
    .level  (sdaLvl),
    .rise   (sdaRise),
    .fall   (sdaFall)
  );

  reg [6:0] state_q;
  reg [2:0] bitCnt_q;
  reg [7:0] shift_q;
  reg [7:0] cmd_q;
  reg       byteIdx_q;
  reg       cmdValid_q;
  reg       revReady_q;
  reg       readMode_q;
  reg       revIdx_q;
  reg       ackDrive_q;
  reg       masterAck_q;

  wire startCond = sdaFall & sclLvl;
  wire stopCond  = sdaRise & sclLvl;

  // True when the second byte is the two's complement of the first
  function cmpl_ok;
    input [7:0] first;
    input [7:0] second;
    begin
      cmpl_ok = ((first + second) == 8'h00);
    end
  endfunction

  // Revision byte selected by index, top byte first
  function [7:0] rev_byte;
    input [15:0] rev;
    input        idx;
    begin
      rev_byte = idx ? rev[7:0] : rev[15:8];
    end
  endfunction

  wire [7:0] rxByte = {shift_q[6:0], sdaLvl};
  // Next revision byte for a read that the master acknowledged
  wire [7:0] nextRev = rev_byte(REV_VALUE, ~revIdx_q);

  always @(posedge clk) begin
    if (!resetn) begin
      state_q     <= S_IDLE;
      bitCnt_q    <= 3'h0;
      shift_q     <= 8'h00;
      cmd_q       <= 8'h00;
      byteIdx_q   <= 1'b0;
      cmdValid_q  <= 1'b0;
      revReady_q  <= 1'b0;
      readMode_q  <= 1'b0;
      revIdx_q    <= 1'b0;
      ackDrive_q  <= 1'b0;
      masterAck_q <= 1'b0;
      sdaOut      <= 1'b1;
      sdaOe       <= 1'b0;
      effectStart <= 1'b0;
      effectIndex <= 4'h0;
      effectAbort <= 1'b0;
      busy        <= 1'b0;
    end else begin
      effectStart <= 1'b0;
      effectAbort <= 1'b0;
      if (stopCond) begin
        // Only a complete, checked write command acts here
        if (cmdValid_q && !readMode_q) begin
          if (cmd_q <= `HICS_LAST_EFFECT) begin
            effectStart <= 1'b1;
            effectIndex <= cmd_q[3:0];
            busy        <= 1'b1;
          end else if (cmd_q == `HICS_CMD_ABORT) begin
            effectAbort <= 1'b1;
            busy        <= 1'b0;
          end
        end
        state_q    <= S_IDLE;
        cmdValid_q <= 1'b0;
        revReady_q <= 1'b0;
        readMode_q <= 1'b0;
        sdaOe      <= 1'b0;
        sdaOut     <= 1'b1;
      end else if (startCond) begin
        // A Start mid-byte cancels; a pending revision survives a Restart
        // The clock rise ahead of a Restart has already clocked in one bit
        if (!(cmdValid_q && cmd_q == `HICS_CMD_REVISION &&
              state_q == S_WBYT && bitCnt_q == 3'h1))
          revReady_q <= 1'b0;
        else
          revReady_q <= 1'b1;
        cmdValid_q <= 1'b0;
        state_q    <= S_ADDR;
        bitCnt_q   <= 3'h0;
        byteIdx_q  <= 1'b0;
        readMode_q <= 1'b0;
        sdaOe      <= 1'b0;
        sdaOut     <= 1'b1;
      end else begin
        case (state_q)
          S_IDLE: begin
            sdaOe <= 1'b0;
          end
          S_ADDR: begin
            if (sclRise) begin
              shift_q  <= rxByte;
              bitCnt_q <= bitCnt_q + 3'h1;
              if (bitCnt_q == 3'h7) begin
                // Read without a staged revision is not a defined command
                if (rxByte[7:1] == `HICS_SLAVE_ADDR &&
                    (!rxByte[0] || revReady_q)) begin
                  state_q    <= S_AACK;
                  readMode_q <= rxByte[0];
                  revIdx_q   <= 1'b0;
                  ackDrive_q <= 1'b0;
                end else begin
                  state_q <= S_IDLE;
                end
              end
            end
          end
          S_AACK: begin
            if (sclFall && !ackDrive_q) begin
              sdaOut     <= 1'b0;
              sdaOe      <= 1'b1;
              ackDrive_q <= 1'b1;
            end else if (sclFall && ackDrive_q) begin
              ackDrive_q <= 1'b0;
              bitCnt_q   <= 3'h0;
              if (readMode_q) begin
                shift_q <= rev_byte(REV_VALUE, revIdx_q);
                sdaOut  <= REV_VALUE[15];
                sdaOe   <= ~REV_VALUE[15];
                state_q <= S_RBYT;
              end else begin
                sdaOe   <= 1'b0;
                sdaOut  <= 1'b1;
                state_q <= S_WBYT;
              end
            end
          end
          S_WBYT: begin
            // A whole bit after a checked pair can only be a third byte;
            // a Stop after the pair still sees one clock rise, so wait
            // for the fall before deciding
            if (sclFall && cmdValid_q && bitCnt_q != 3'h0) begin
              cmdValid_q <= 1'b0;
              state_q    <= S_IDLE;
            end else if (sclRise) begin
              shift_q  <= rxByte;
              bitCnt_q <= bitCnt_q + 3'h1;
              if (bitCnt_q == 3'h7) begin
                if (!byteIdx_q) begin
                  cmd_q <= rxByte;
                  if (rxByte > `HICS_CMD_ABORT)
                    state_q <= S_IDLE;
                  else
                    state_q <= S_WACK;
                end else if (cmpl_ok(cmd_q, rxByte)) begin
                  cmdValid_q <= 1'b1;
                  state_q    <= S_WACK;
                end else begin
                  state_q <= S_IDLE;
                end
              end
            end
          end
          S_WACK: begin
            if (sclFall && !ackDrive_q) begin
              sdaOut     <= 1'b0;
              sdaOe      <= 1'b1;
              ackDrive_q <= 1'b1;
            end else if (sclFall && ackDrive_q) begin
              ackDrive_q <= 1'b0;
              sdaOe      <= 1'b0;
              sdaOut     <= 1'b1;
              bitCnt_q   <= 3'h0;
              // Only a Stop or Restart may follow the second byte
              byteIdx_q  <= 1'b1;
              state_q    <= S_WBYT;
            end
          end
          S_RBYT: begin
            if (sclFall) begin
              bitCnt_q <= bitCnt_q + 3'h1;
              if (bitCnt_q == 3'h7) begin
                sdaOe   <= 1'b0; // Release for master acknowledge
                sdaOut  <= 1'b1;
                state_q <= S_RACK;
              end else begin
                sdaOut  <= shift_q[6];
                sdaOe   <= ~shift_q[6];
                shift_q <= {shift_q[6:0], 1'b0};
              end
            end
          end
          S_RACK: begin
            if (sclRise)
              masterAck_q <= ~sdaLvl;
            if (sclFall) begin
              bitCnt_q <= 3'h0;
              if (masterAck_q) begin
                // Alternate bytes until a master not-acknowledge, Stop or Restart
                shift_q  <= nextRev;
                sdaOut   <= nextRev[7];
                sdaOe    <= ~nextRev[7];
                revIdx_q <= ~revIdx_q;
                state_q  <= S_RBYT;
              end else begin
                state_q <= S_IDLE;
              end
            end
          end
          default: begin
            state_q <= S_IDLE;
            sdaOe   <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// [design/hics_pin_sync.v]
// Two-flop synchroniser with edge detection for the serial bus pins.
// Assumes asynchronous pin levels; idle state of both lines is high.
`timescale 1ns/10ps
module hics_pin_sync (
  // Clock and reset
  input  wire clk,
  input  wire resetn,
  // Raw pin level
  input  wire pinIn,
  // Synchronised level and edges
  output reg  level,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg prev_q;

  // First flop only feeds the second
  always @(posedge clk) begin
    if (!resetn) begin
      meta_q <= 1'b1;
      level  <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= pinIn;
      level  <= meta_q;
      prev_q <= level;
    end
  end

  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;
endmodule

// [testbench/hics_command_slave_props.sv]
// Checker for the command slave: actions tied to pin conditions.
// Assumes binding to hics_command_slave; sees its ports only.
`timescale 1ns/10ps
module hics_command_slave_props (
  // Clock and reset
  input wire       clk,
  input wire       resetn,
  // Bus pins
  input wire       sclIn,
  input wire       sdaIn,
  input wire       sdaOut,
  input wire       sdaOe,
  // Actions
  input wire       effectStart,
  input wire [3:0] effectIndex,
  input wire       effectAbort,
  input wire       busy
);
  reg       sdaLast_q;
  reg [3:0] since_q;
  wire      stopSeen = sclIn & sdaIn & ~sdaLast_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Cycles since a Stop at the pins; saturates so it never wraps
  always @(posedge clk) begin
    sdaLast_q <= sdaIn;
    if (!resetn)
      since_q <= 4'hF;
    else if (stopSeen)
      since_q <= 4'h0;
    else if (since_q != 4'hF)
      since_q <= since_q + 4'h1;
  end
  a_start_at_stop: assert property (effectStart |-> since_q inside {[2:8]})
    else $error("effect start not just after a stop");
  a_abort_at_stop: assert property (effectAbort |-> since_q inside {[2:8]})
    else $error("abort not just after a stop");
  a_start_pulse: assert property (effectStart |=> !effectStart)
    else $error("effect start longer than one cycle");
  a_busy_set: assert property (effectStart && !effectAbort |=> busy[*2])
    else $error("busy not set by effect start");
  a_busy_clear: assert property (effectAbort |=> !busy)
    else $error("busy not cleared by abort");
  a_drive_low: assert property (sdaOe |-> !sdaOut)
    else $error("data driven high");
  a_idle_release: assert property (since_q == 4'h8 |-> !sdaOe)
    else $error("data held after stop");
  a_index_range: assert property (effectStart |-> effectIndex <= 4'hD)
    else $error("effect index out of range");
  a_index_held: assert property (!effectStart |-> $stable(effectIndex))
    else $error("effect index moved without start");
  a_one_action: assert property (!(effectStart && effectAbort))
    else $error("start and abort together");
endmodule
bind hics_command_slave hics_command_slave_props u_props (
  .clk(clk), .resetn(resetn), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .effectStart(effectStart),
  .effectIndex(effectIndex), .effectAbort(effectAbort), .busy(busy));

// [testbench/hics_tb_master.sv]
// Bus master model: driven clock, open-drain data, 80 ns bit period.
// Assumes pull-ups on both lines; steps on the falling edge of clk.
`timescale 1ns/10ps
module hics_tb_master (
  // Clock
  input  wire clk,
  // Bus lines
  input  wire sdaLine,
  output reg  sclOut,
  output reg  sdaLow
);
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end
  task q(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // Low phase 5 cycles, so a slave edge never lands on the clock rise
  task bitx(input b, output s);
    begin
      sdaLow = ~b;
      q(3);
      sclOut = 1'b1;
      q(2);
      s = sdaLine;
      q(1);
      sclOut = 1'b0;
      q(2);
    end
  endtask
  // Start or repeated start; the extra wait lets a slave ack clear
  task start;
    begin
      sdaLow = 1'b0;
      q(4);
      sclOut = 1'b1;
      q(2);
      sdaLow = 1'b1;
      q(2);
      sclOut = 1'b0;
      q(2);
    end
  endtask
  task stop;
    begin
      sdaLow = 1'b1;
      q(3);
      sclOut = 1'b1;
      q(2);
      sdaLow = 1'b0;
      q(2);
    end
  endtask
  // Byte MSB first, then a ninth bit nb; ack is the line seen low
  task xfer(input [7:0] d, input nb, output [7:0] r, output ack);
    integer i;
    reg     s;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bitx(d[i], r[i]);
      end
      bitx(nb, s);
      ack = ~s;
    end
  endtask
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the command slave with a modelled master.
// Assumes the master model and the checker are compiled first.
`timescale 1ns/10ps
`include "hics_map.vh"
module testbench;
  localparam [15:0] REV = `HICS_REV_DEFAULT;
  reg         clk, resetn, ak, es, ea, bz;
  wire        scl, sda, sdaOut, sdaOe, sdaLow, eStart, eAbort, busy;
  wire [3:0]  eIdx;
  reg  [17:0] rows [0:17];
  reg  [7:0]  nS, nA, n0, n1, c, s, r;
  integer     err_total, checks_done, i;
  // Either party pulling low wins over the pull-up
  assign sda = ~(sdaLow | (sdaOe & ~sdaOut));
  hics_command_slave uut (.clk(clk), .resetn(resetn), .sclIn(scl),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .effectStart(eStart),
    .effectIndex(eIdx), .effectAbort(eAbort), .busy(busy));
  hics_tb_master m (.clk(clk), .sdaLine(sda), .sclOut(scl), .sdaLow(sdaLow));
  always @(posedge clk) begin
    if (!resetn) begin
      nS <= 8'h00;
      nA <= 8'h00;
    end else begin
      if (eStart === 1'b1) nS <= nS + 8'h01;
      if (eAbort === 1'b1) nA <= nA + 8'h01;
    end
  end
  task check(input [63:0] nm, input [7:0] seen, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task tx(input [7:0] d);
    m.xfer(d, 1'b1, r, ak);
  endtask
  task wf(input [7:0] cc, input [7:0] ss);
    begin
      m.start;
      tx(8'h20);
      check("addrAck", {7'h0, ak}, 8'h01);
      tx(cc);
      tx(ss);
      m.stop;
      repeat (8) @(negedge clk);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if ((err_total == 0) && (checks_done > 0))
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // A run needs well under 100 us
  initial begin
    #300000;
    err_total = err_total + 1;
    print_verdict;
  end
  initial begin
    resetn = 1'b0;
    err_total = 0;
    checks_done = 0;
    bz = 1'b0;
    for (i = 0; i < 14; i = i + 1) begin
      rows[i] = {i[7:0], 8'h00 - i[7:0], 2'b10};
    end
    rows[14] = {8'h0F, 8'hF1, 2'b01};
    rows[15] = {8'h03, 8'hFC, 2'b00};
    rows[16] = {8'h10, 8'hF0, 2'b00};
    rows[17] = {8'h0E, 8'hF2, 2'b00};
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    for (i = 0; i < 18; i = i + 1) begin
      {c, s, es, ea} = rows[i];
      n0 = nS;
      n1 = nA;
      wf(c, s);
      bz = (bz | es) & ~ea;
      check("start", nS - n0, {7'h0, es});
      check("abort", nA - n1, {7'h0, ea});
      check("busy", {7'h0, busy}, {7'h0, bz});
      if (es) check("index", {4'h0, eIdx}, c);
    end
    $display("test rows done");
    n0 = nS;
    m.start;
    tx(8'h22);
    check("badAddr", {7'h0, ak}, 8'h00);
    m.start;
    tx(8'h00);
    check("genCall", {7'h0, ak}, 8'h00);
    m.stop;
    m.start;
    tx(8'h20);
    tx(8'h05);
    m.start;
    m.stop;
    m.start;
    tx(8'h20);
    tx(8'h06);
    m.stop;
    m.start;
    tx(8'h20);
    tx(8'h07);
    tx(8'hF9);
    tx(8'h00);
    check("third", {7'h0, ak}, 8'h00);
    m.stop;
    m.start;
    tx(8'h20);
    tx(8'h12);
    tx(8'hEE);
    check("ignored", {7'h0, ak}, 8'h00);
    m.stop;
    repeat (8) @(negedge clk);
    check("abandon", nS - n0, 8'h00);
    $display("test aborts done");
    m.start;
    tx(8'h20);
    tx(8'h0E);
    tx(8'hF2);
    m.start;
    tx(8'h21);
    check("readAck", {7'h0, ak}, 8'h01);
    m.xfer(8'hFF, 1'b0, r, ak);
    check("revHigh", r, REV[15:8]);
    m.xfer(8'hFF, 1'b0, r, ak);
    check("revLow", r, REV[7:0]);
    m.xfer(8'hFF, 1'b1, r, ak);
    check("revMore", r, REV[15:8]);
    m.stop;
    m.start;
    tx(8'h21);
    check("unprimed", {7'h0, ak}, 8'h00);
    m.stop;
    $display("test revision done");
    wf(8'h09, 8'hF7);
    resetn = 1'b0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    check("rstBusy", {7'h0, busy}, 8'h00);
    check("rstOe", {7'h0, sdaOe}, 8'h00);
    check("rstIdx", {4'h0, eIdx}, 8'h00);
    $display("test reset done");
    print_verdict;
  end
endmodule
